// *** core/csb_core.sv ***
`timescale 1ns/1ps
`include "csb_cfg.svh"
module csb_core (
   input  wire logic                     clk_sys_i,
   input  wire logic                     rstn_i,
   // processor access request
   input  wire logic                     cpu_req_i,
   input  wire logic                     cpu_write_i,
   input  wire logic [`CSB_UNIT_W-1:0]   cpu_unit_i,
   input  wire logic [`CSB_ADDR_W-1:0]   cpu_addr_i,
   input  wire logic [`CSB_DATA_W-1:0]   cpu_wdata_i,
   output logic                          cpu_grant_o,
   output logic                          cpu_done_o,
   output logic [`CSB_DATA_W-1:0]        cpu_rdata_o,
   output logic                          cpu_perr_o,
   // autonomous channel requests
   input  wire logic [`CSB_CHANS-1:0]    chan_req_i,
   output logic [`CSB_CHANS-1:0]         chan_accept_o,
   // store bus
   output logic [`CSB_UNITS-1:0]         store_select_o,
   output logic                          trigger_read_o,
   output logic                          permit_write_o,
   output logic                          inhibit_readout_o,
   output logic [`CSB_DATA_W-1:0]        addr_data_o,
   input  wire logic                     read_busy_i,
   input  wire logic                     write_busy_i,
   input  wire logic [`CSB_DATA_W-1:0]   data_in_i,
   input  wire logic                     parity_err_i,
   // power and control panel
   input  wire logic                     store_interlock_i,
   input  wire logic                     switch_off_i,
   input  wire logic                     line_volt_fault_i,
   input  wire logic                     store_temp_fault_i,
   input  wire logic                     supply_ok_i,
   input  wire logic [1:0]               panel_mode_i,
   input  wire logic                     reset_key_i,
   input  wire logic                     jump_key_i,
   output logic                          store_reset_o,
   output logic                          cpu_reset_o,
   // program level
   input  wire logic [1:0]               prog_level_i,
   output logic                          level_indicator_low_o,
   output logic                          level_indicator_high_o
);
   // store bus, channel and panel inputs pass the three-stage synchroniser; processor request and level inputs do not
   localparam int NS = 2 + `CSB_DATA_W + 1 + `CSB_CHANS + 9;
   logic [NS-1:0] raw_w;
   logic [NS-1:0] syn_w;
   assign raw_w = {read_busy_i, write_busy_i, data_in_i, parity_err_i, chan_req_i,
                   store_interlock_i, switch_off_i, line_volt_fault_i, store_temp_fault_i,
                   supply_ok_i, panel_mode_i, reset_key_i, jump_key_i};
   csb_sync #(.W(NS)) u_sync (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .async_i   (raw_w),
      .sync_o    (syn_w)
   );
   logic                   rb_w;
   logic                   wb_w;
   logic [`CSB_DATA_W-1:0] din_w;
   logic                   perr_w;
   logic [`CSB_CHANS-1:0]  creq_w;
   logic                   ilk_w;
   logic                   off_w;
   logic                   vflt_w;
   logic                   tflt_w;
   logic                   sok_w;
   logic [1:0]             mode_w;
   logic                   rkey_w;
   logic                   jkey_w;
   assign {rb_w, wb_w, din_w, perr_w, creq_w, ilk_w, off_w, vflt_w, tflt_w,
           sok_w, mode_w, rkey_w, jkey_w} = syn_w;

   // fixed priority pick, lowest index first
   function automatic logic [`CSB_CHANS-1:0] pick(input logic [`CSB_CHANS-1:0] r);
      logic [`CSB_CHANS-1:0] g;
      g = '0;
      for (int i = `CSB_CHANS - 1; i >= 0; i--) begin
         if (r[i]) begin
            g = '0;
            g[i] = 1'b1;
         end
      end
      return g;
   endfunction : pick

   csb_pkg::csb_state_t    st_r;
   csb_pkg::csb_state_t    st_nxt;
   logic                   cpu_cyc_r;
   logic                   wr_r;
   logic [`CSB_UNIT_W-1:0] unit_r;
   logic [`CSB_DATA_W-1:0] wdata_r;
   logic [`CSB_DATA_W-1:0] bus_r;
   logic [`CSB_UNITS-1:0]  sel_r;
   logic                   trig_r;
   logic                   inh_r;
   logic [`CSB_CHANS-1:0]  acc_r;
   logic                   grant_r;
   logic                   done_r;
   logic [`CSB_DATA_W-1:0] rdata_r;
   logic                   perr_r;
   logic                   rb_d_r;
   logic                   wb_d_r;

   // arbitration decode: channels before processor
   logic [`CSB_CHANS-1:0]  win_w;
   logic                   any_chan_w;
   logic                   start_cpu_w;
   logic                   run_w;
   logic                   rb_fall_w;
   logic                   wb_fall_w;
   logic                   rb_rise_w;
   assign win_w       = pick(creq_w);
   assign any_chan_w  = |creq_w;
   assign start_cpu_w = cpu_req_i && !any_chan_w;
   assign run_w       = store_reset_o && !cpu_reset_o;
   assign rb_rise_w   = rb_w && !rb_d_r;
   assign rb_fall_w   = !rb_w && rb_d_r;
   assign wb_fall_w   = !wb_w && wb_d_r;

   // cycle sequencer; a channel cycle drives no bus, the channel does
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         csb_pkg::CSB_IDLE: begin
            if (run_w && (any_chan_w || start_cpu_w)) begin
               st_nxt = any_chan_w ? csb_pkg::CSB_WAIT_WB : csb_pkg::CSB_ADDR;
            end
         end
         csb_pkg::CSB_ADDR:     st_nxt = csb_pkg::CSB_WAIT_RB;
         csb_pkg::CSB_WAIT_RB:  if (rb_rise_w) st_nxt = csb_pkg::CSB_WAIT_RBF;
         csb_pkg::CSB_WAIT_RBF: if (rb_fall_w) st_nxt = csb_pkg::CSB_WAIT_WB;
         csb_pkg::CSB_WAIT_WB:  if (wb_w) st_nxt = csb_pkg::CSB_WAIT_WBF;
         csb_pkg::CSB_WAIT_WBF: if (wb_fall_w) st_nxt = csb_pkg::CSB_END;
         csb_pkg::CSB_END:      st_nxt = csb_pkg::CSB_IDLE;
         default:               st_nxt = csb_pkg::CSB_IDLE;
      endcase
   end

   // state and busy edge history
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i || cpu_reset_o) begin
         st_r   <= csb_pkg::CSB_IDLE;
         rb_d_r <= 1'b0;
         wb_d_r <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         rb_d_r <= rb_w;
         wb_d_r <= wb_w;
      end
   end

   // bus drive; strobes only raised a cycle after select and address settle
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i || cpu_reset_o) begin
         cpu_cyc_r <= 1'b0;
         wr_r      <= 1'b0;
         unit_r    <= '0;
         wdata_r   <= '0;
         bus_r     <= '0;
         sel_r     <= '0;
         trig_r    <= 1'b0;
         inh_r     <= 1'b0;
         acc_r     <= '0;
         grant_r   <= 1'b0;
      end else begin
         grant_r <= 1'b0;
         if (st_r == csb_pkg::CSB_IDLE && st_nxt != csb_pkg::CSB_IDLE) begin
            acc_r     <= win_w;
            cpu_cyc_r <= !any_chan_w;
            grant_r   <= !any_chan_w;
            if (!any_chan_w) begin
               wr_r    <= cpu_write_i;
               unit_r  <= cpu_unit_i;
               wdata_r <= cpu_wdata_i;
               bus_r   <= {{(`CSB_DATA_W-`CSB_ADDR_W){1'b0}}, cpu_addr_i};
               sel_r   <= `CSB_UNITS'(1) << cpu_unit_i;
            end
         end
         if (st_r == csb_pkg::CSB_ADDR) begin
            trig_r <= 1'b1;
            inh_r  <= wr_r;
         end
         // write data replaces the address once read busy is seen
         if (st_r == csb_pkg::CSB_WAIT_RB && rb_rise_w) begin
            bus_r <= wr_r ? wdata_r : '0;
         end
         if (st_r == csb_pkg::CSB_WAIT_WBF && wb_fall_w) begin
            trig_r    <= 1'b0;
            inh_r     <= 1'b0;
            bus_r     <= '0;
            sel_r     <= '0;
            acc_r     <= '0;
            cpu_cyc_r <= 1'b0;
         end
      end
   end
   logic unused_w;
   assign unused_w = ^unit_r;

   // read capture and completion back to the processor
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         done_r  <= 1'b0;
         rdata_r <= '0;
         perr_r  <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (cpu_cyc_r && st_r == csb_pkg::CSB_WAIT_WBF) begin
            rdata_r <= din_w;
            perr_r  <= perr_r | perr_w;
         end
         if (st_r == csb_pkg::CSB_IDLE && st_nxt != csb_pkg::CSB_IDLE) begin
            perr_r <= 1'b0;
         end
         if (cpu_cyc_r && st_r == csb_pkg::CSB_WAIT_WBF && wb_fall_w) begin
            done_r <= 1'b1;
         end
      end
   end

   // supply failure timer: only outages longer than the window reset the machine
   logic [`CSB_CNT_W-1:0] fail_cnt_r;
   logic                  fail_long_w;
   assign fail_long_w = (fail_cnt_r >= `CSB_CNT_W'(`CSB_FAIL_CYC));
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i || sok_w) begin
         fail_cnt_r <= '0;
      end else if (!fail_long_w) begin
         fail_cnt_r <= fail_cnt_r + `CSB_CNT_W'(1);
      end
   end

   // store reset and processor reset; manual modes wait for the jump key
   logic hold_r;
   logic fault_w;
   logic manual_w;
   assign fault_w  = off_w || vflt_w || tflt_w || fail_long_w;
   assign manual_w = (mode_w != 2'(csb_pkg::CSB_MODE_AUTO));
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         hold_r        <= 1'b1;
         store_reset_o <= 1'b0;
         cpu_reset_o   <= 1'b1;
      end else begin
         if (fault_w || (manual_w && rkey_w)) begin
            hold_r <= 1'b1;
         end else if (jkey_w || !manual_w) begin
            hold_r <= 1'b0;
         end
         store_reset_o <= !fault_w && ilk_w && !hold_r;
         cpu_reset_o   <= fault_w || hold_r;
      end
   end

   // registered outputs
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         level_indicator_low_o  <= 1'b0;
         level_indicator_high_o <= 1'b0;
      end else begin
         level_indicator_low_o  <= prog_level_i[0];
         level_indicator_high_o <= prog_level_i[1];
      end
   end
   assign store_select_o    = sel_r;
   assign trigger_read_o    = trig_r;
   assign permit_write_o    = trig_r;
   assign inhibit_readout_o = inh_r;
   assign addr_data_o       = bus_r;
   assign chan_accept_o     = acc_r;
   assign cpu_grant_o       = grant_r;
   assign cpu_done_o        = done_r;
   assign cpu_rdata_o       = rdata_r;
   assign cpu_perr_o        = perr_r;
endmodule : csb_core

// *** core/csb_cfg.svh ***
`ifndef CSB_CFG_SVH
`define CSB_CFG_SVH
// widths
`define CSB_DATA_W        18
`define CSB_ADDR_W        14
`define CSB_UNITS         8
`define CSB_UNIT_W        3
`define CSB_CHANS         4
// supply failure window: 10 us at 10 ns per cycle
`define CSB_FAIL_NS       10000
`define CSB_CLK_NS        10
`define CSB_FAIL_CYC      (`CSB_FAIL_NS / `CSB_CLK_NS)
`define CSB_CNT_W         11
`endif

// *** core/csb_pkg.sv ***
package csb_pkg;
   typedef enum logic [2:0] {
      CSB_IDLE,
      CSB_ADDR,
      CSB_WAIT_RB,
      CSB_WAIT_RBF,
      CSB_WAIT_WB,
      CSB_WAIT_WBF,
      CSB_END
   } csb_state_t;
   typedef enum logic [1:0] {
      CSB_MODE_AUTO,
      CSB_MODE_MANUAL,
      CSB_MODE_TEST
   } csb_mode_t;
endpackage : csb_pkg

// *** core/csb_sync.sv ***
`timescale 1ns/1ps
// three-stage input synchroniser; output changes once stages two and three agree
module csb_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys_i,
   input  wire logic         rstn_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] q_r;
   // first stage feeds only the second, avoiding metastable fan-out
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q_r  <= '0;
      end else begin
         s1_r <= async_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               q_r[i] <= s3_r[i];
            end
         end
      end
   end
   assign sync_o = q_r;
endmodule : csb_sync

// *** testbench/csb_core_properties.sv ***
`timescale 1ns/1ps
// checker on the store bus ports of csb_core
module csb_core_props (
   input wire logic        clk_sys_i,
   input wire logic        rstn_i,
   input wire logic        trigger_read_o,
   input wire logic        permit_write_o,
   input wire logic        inhibit_readout_o,
   input wire logic [7:0]  store_select_o,
   input wire logic [3:0]  chan_accept_o,
   input wire logic [17:0] addr_data_o,
   input wire logic        write_busy_i,
   input wire logic        switch_off_i,
   input wire logic [1:0]  prog_level_i,
   input wire logic        level_indicator_low_o,
   input wire logic        level_indicator_high_o,
   input wire logic        store_reset_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   // strobes live only inside a selected cycle
   a_strobe_sel: assert property (trigger_read_o |-> $onehot(store_select_o))
      else $error("strobe without one select");
   a_strobe_pair: assert property (permit_write_o == trigger_read_o)
      else $error("trigger and permit differ");
   a_inhibit_trig: assert property (inhibit_readout_o |-> trigger_read_o)
      else $error("inhibit without trigger");
   a_sel_onehot: assert property ($onehot0(store_select_o))
      else $error("two units selected");
   // accept is one channel and stands for four cycles after it rises
   a_accept_one: assert property ($onehot0(chan_accept_o))
      else $error("two accepts");
   a_accept_hold: assert property ($rose(|chan_accept_o) |=> $stable(chan_accept_o) [*4])
      else $error("accept dropped early");
   // cycle end: strobes fall with select, after write busy
   a_end_clear: assert property ($fell(trigger_read_o) |-> store_select_o == 8'h00 && !inhibit_readout_o)
      else $error("select left after strobe end");
   a_wb_end: assert property ($fell(write_busy_i) && trigger_read_o |-> ##[1:8] !trigger_read_o)
      else $error("cycle not ended after write busy");
   a_data_held: assert property (inhibit_readout_o && write_busy_i && $past(write_busy_i) |-> $stable(addr_data_o))
      else $error("write data moved");
   // sync latency is about five edges, so eight is a safe bound
   a_switch_off: assert property (switch_off_i [*8] |-> !store_reset_o)
      else $error("store reset true at switch off");
   a_level_copy: assert property ($past(rstn_i) |-> {level_indicator_high_o, level_indicator_low_o} == $past(prog_level_i))
      else $error("level lines wrong");
endmodule : csb_core_props
bind csb_core csb_core_props csb_core_props_i (.clk_sys_i, .rstn_i, .trigger_read_o, .permit_write_o,
   .inhibit_readout_o, .store_select_o, .chan_accept_o, .addr_data_o, .write_busy_i, .switch_off_i,
   .prog_level_i, .level_indicator_low_o, .level_indicator_high_o, .store_reset_o);

// *** testbench/csb_store_model.sv ***
`timescale 1ns/1ps
// behavioural core store; rb_len_i stretches read busy for slow units
module csb_store_model (
   input  wire logic        clk_sys_i,
   input  wire logic        go_i,
   input  wire logic        wr_i,
   input  wire logic [17:0] bus_i,
   input  wire logic        bad_i,
   input  wire logic [3:0]  rb_len_i,
   output logic             read_busy_o,
   output logic             write_busy_o,
   output logic [17:0]      data_o,
   output logic             perr_o
);
   logic [17:0] mem [16];
   logic [3:0]  adr;
   int          cnt;
   initial begin
      foreach (mem[i]) mem[i] = 18'h00000;
      {read_busy_o, write_busy_o, perr_o, data_o, adr} = '0;
      cnt = 0;
   end
   // cnt 0 is idle; count stops early so a quick next strobe is not missed
   always @(posedge clk_sys_i) begin
      if (cnt == 0 && go_i) begin
         adr <= bus_i[3:0];
         cnt <= 1;
      end else if (cnt > 0 && cnt < 26 + rb_len_i) cnt <= cnt + 1;
      else if (cnt > 0 && !go_i) begin
         cnt <= 0;
         data_o <= 18'h00000;
         perr_o <= 1'b0;
      end
      if (cnt == 2) read_busy_o <= 1'b1;
      if (cnt == 2 + rb_len_i) begin
         read_busy_o <= 1'b0;
         data_o <= mem[adr];
      end
      if (cnt == 4 + rb_len_i) write_busy_o <= 1'b1;
      if (cnt == 17 + rb_len_i) perr_o <= bad_i;
      if (cnt == 24 + rb_len_i) begin
         write_busy_o <= 1'b0;
         if (wr_i) mem[adr] <= bus_i;
      end
   end
endmodule : csb_store_model

// *** testbench/csb_core_tb_top.sv ***
`timescale 1ns/1ps
// bench: drives at falling edge, samples there too
module csb_core_tb_top;
   logic        clk_sys_i = '0, rstn_i = '0, cpu_req_i = '0, cpu_write_i = '0, bad = '0;
   logic        supply_ok_i = 1'h1, reset_key_i = '0, jump_key_i = '0;
   logic [2:0]  cpu_unit_i = '0;
   logic [13:0] cpu_addr_i = '0;
   logic [17:0] cpu_wdata_i = '0, cpu_rdata_o, addr_data_o, data_in_i;
   logic [3:0]  chan_req_i = '0, flt = '0, rb_len = 4'h6, chan_accept_o;
   logic [1:0]  panel_mode_i = '0, prog_level_i = '0;
   logic [7:0]  store_select_o;
   logic        cpu_grant_o, cpu_done_o, cpu_perr_o, trigger_read_o, permit_write_o, inhibit_readout_o;
   logic        read_busy_i, write_busy_i, parity_err_i, store_reset_o, cpu_reset_o;
   logic        level_indicator_low_o, level_indicator_high_o;
   int          n_fail = 0, comparisons = 0, exp_mem [16];
   csb_core csb_core_i (.clk_sys_i, .rstn_i, .cpu_req_i, .cpu_write_i, .cpu_unit_i, .cpu_addr_i, .cpu_wdata_i,
      .cpu_grant_o, .cpu_done_o, .cpu_rdata_o, .cpu_perr_o, .chan_req_i, .chan_accept_o, .store_select_o,
      .trigger_read_o, .permit_write_o, .inhibit_readout_o, .addr_data_o, .read_busy_i, .write_busy_i,
      .data_in_i, .parity_err_i, .store_interlock_i(!flt[3]), .switch_off_i(flt[0]),
      .line_volt_fault_i(flt[1]), .store_temp_fault_i(flt[2]), .supply_ok_i, .panel_mode_i, .reset_key_i,
      .jump_key_i, .store_reset_o, .cpu_reset_o, .prog_level_i, .level_indicator_low_o, .level_indicator_high_o);
   csb_store_model csb_store_model_i (.clk_sys_i, .go_i(trigger_read_o | (|chan_accept_o)),
      .wr_i(inhibit_readout_o), .bus_i(addr_data_o), .bad_i(bad), .rb_len_i(rb_len),
      .read_busy_o(read_busy_i), .write_busy_o(write_busy_i), .data_o(data_in_i), .perr_o(parity_err_i));
   // clock and watchdog; the run needs well under 20000 cycles
   initial forever #5 clk_sys_i = ~clk_sys_i;
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      n_fail++;
      summarize();
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask : cyc
   task automatic chk_word(input logic [17:0] got, input logic [17:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word
   task automatic chk_flag(input logic got, input logic exp);
      chk_word({17'h00000, got}, {17'h00000, exp});
   endtask : chk_flag
   task automatic summarize();
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : summarize
   // one processor cycle; request held until grant is seen
   task automatic cpu_cycle(input logic w, input logic [2:0] u, input logic [13:0] a, input logic [17:0] d,
                            input logic b);
      int k;
      {cpu_write_i, cpu_unit_i, cpu_addr_i, cpu_wdata_i, bad, cpu_req_i} = {w, u, a, d, b, 1'b1};
      for (k = 0; k < 300 && cpu_grant_o !== 1'b1; k++) cyc(1);
      cpu_req_i = 1'b0;
      chk_word({10'h000, store_select_o}, 18'h00001 << u);
      chk_word(addr_data_o, {4'h0, a});
      // strobes follow one edge after select and address
      cyc(1);
      chk_flag(trigger_read_o, 1'b1);
      chk_flag(permit_write_o, 1'b1);
      chk_flag(inhibit_readout_o, w);
      for (k = 0; k < 300 && cpu_done_o !== 1'b1; k++) begin
         if (w && write_busy_i) chk_word(addr_data_o, d);
         cyc(1);
      end
      chk_flag(cpu_done_o, 1'b1);
      chk_word({10'h000, store_select_o}, 18'h00000);
      chk_flag(trigger_read_o, 1'b0);
      if (!w) chk_word(cpu_rdata_o, exp_mem[a[3:0]][17:0]);
      chk_flag(cpu_perr_o, b);
      if (w) exp_mem[a[3:0]] = d;
   endtask : cpu_cycle
   // channels granted in priority order, processor waits behind them
   task automatic chan_test(input logic [3:0] p);
      int k, w;
      chan_req_i = p;
      cyc(8);
      cpu_req_i = 1'b1;
      while (chan_req_i != 4'h0) begin
         for (k = 0; k < 300 && chan_accept_o === 4'h0; k++) begin
            chk_flag(cpu_grant_o, 1'b0);
            cyc(1);
         end
         w = 0;
         while (!chan_req_i[w]) w++;
         chk_word({14'h0000, chan_accept_o}, 18'h00001 << w);
         chan_req_i[w] = 1'b0;
         for (k = 0; k < 300 && chan_accept_o !== 4'h0; k++) cyc(1);
      end
      cpu_cycle(1'b0, 3'h2, 14'h0005, 18'h00000, 1'b0);
   endtask : chan_test
   initial begin
      int i;
      logic [13:0] a;
      void'($urandom(32'h1528544E));
      cyc(6);
      rstn_i = 1'b1;
      cyc(20);
      chk_flag(store_reset_o, 1'b1);
      chk_flag(cpu_reset_o, 1'b0);
      for (i = 0; i < 8; i++) begin
         rb_len = i[0] ? 4'hC : 4'h6;
         a = 14'($urandom);
         cpu_cycle(1'b1, 3'($urandom), a, 18'($urandom), 1'b0);
         cpu_cycle(1'b0, 3'($urandom), a, 18'h00000, i == 3);
         prog_level_i = 2'($urandom);
         cyc(2);
         chk_word({16'h0000, level_indicator_high_o, level_indicator_low_o}, {16'h0000, prog_level_i});
      end
      $display("read write test done");
      for (i = 0; i < 4; i++) chan_test(4'($urandom_range(15, 1)));
      $display("channel test done");
      // faults one at a time; the last one drops the store interlock
      for (i = 0; i < 4; i++) begin
         flt = 4'h1 << i;
         cyc(12);
         chk_flag(store_reset_o, 1'b0);
         flt = 4'h0;
         cyc(20);
         chk_flag(store_reset_o, 1'b1);
      end
      $display("fault test done");
      // manual and test: reset key holds the store until jump
      for (i = 1; i < 3; i++) begin
         panel_mode_i = 2'(i);
         reset_key_i = 1'b1;
         cyc(8);
         reset_key_i = 1'b0;
         cyc(30);
         chk_flag(store_reset_o, 1'b0);
         jump_key_i = 1'b1;
         cyc(8);
         jump_key_i = 1'b0;
         cyc(20);
         chk_flag(store_reset_o, 1'b1);
      end
      $display("panel test done");
      panel_mode_i = 2'h0;
      supply_ok_i = 1'b0;
      cyc(500);
      chk_flag(cpu_reset_o, 1'b0);
      supply_ok_i = 1'b1;
      cyc(20);
      chk_flag(cpu_reset_o, 1'b0);
      supply_ok_i = 1'b0;
      cyc(1100);
      chk_flag(cpu_reset_o, 1'b1);
      chk_flag(store_reset_o, 1'b0);
      supply_ok_i = 1'b1;
      cyc(30);
      chk_flag(store_reset_o, 1'b1);
      chk_flag(cpu_reset_o, 1'b0);
      $display("power test done");
      summarize();
   end
endmodule : csb_core_tb_top
